// ### freeze_mode_wake_matcher.sv
`timescale 1ns/10ps
`default_nettype none
`include "wake_params.svh"
module freeze_mode_wake_matcher #(
  parameter int NPINS = 4,
  parameter int SRAM_WORDS = 16
) (
  input wire logic clk, // 40 MHz always-on clock
  input wire logic srst, // Sync reset, active high
  input wire logic ce, // Clock enable
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [NPINS-1:0] wake_pins, // Async wake pins
  output logic frozen, // High while in freeze
  output logic irq // Level interrupt
);
  // ==========================================
  // Elaboration checks
  if (NPINS < 1 || NPINS > 32)
  begin : gen_bad_npins
    $error("NPINS out of range");
  end
  if (SRAM_WORDS < 1 || SRAM_WORDS > 256)
  begin : gen_bad_sram_words
    $error("SRAM_WORDS out of range");
  end
  localparam int SADDR_W = (SRAM_WORDS > 1) ? $clog2(SRAM_WORDS) : 1;
  localparam logic [11:0] SRAM_BASE = `SRAM_BASE_ADDR;

  // ==========================================
  // Pin synchroniser and edge tracking
  logic [NPINS-1:0] sync1_reg, sync2_reg, prev_reg;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end
    else if (ce)
    begin
      sync1_reg <= wake_pins;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // ==========================================
  // Registers and state
  wake_pkg::wake_cfg_type cfg_reg;
  wake_pkg::pstate_type state_reg, state_next;
  logic [2:0] ctrl_reg;
  logic [31:0] alarm_reg, count_reg;
  logic [`IRQ_BITS-1:0] irq_stat_reg, irq_mask_reg;
  logic [31:0] prdata_reg;
  logic [31:0] sram [SRAM_WORDS];

  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire in_freeze = (state_reg == wake_pkg::st_freeze);
  wire sram_hit = (paddr >= SRAM_BASE) && (paddr < SRAM_BASE + 12'(SRAM_WORDS * 4));
  wire [SADDR_W-1:0] sram_idx = SADDR_W'((paddr - SRAM_BASE) >> 2);
  wire [NPINS-1:0] en_n = cfg_reg.sig_en[NPINS-1:0];
  wire [NPINS-1:0] lvl_n = cfg_reg.sig_lvl[NPINS-1:0];
  wire [NPINS-1:0] chg_n = cfg_reg.chg_en[NPINS-1:0];
  // per-pin target level (1 = wake on high, 0 = wake on low)
  wire [NPINS-1:0] pin_match = ~(sync2_reg ^ lvl_n) | ~en_n;
  wire sig_hit = (|en_n) && (&pin_match);
  wire chg_hit = |((sync2_reg ^ prev_reg) & chg_n);
  wire alarm_hit = ctrl_reg[`CTRL_ALARM_ARM] && (count_reg == alarm_reg);
  wire wake_evt = sig_hit || chg_hit || alarm_hit;
  wire freeze_req = wr_en && (paddr == `ADDR_CTRL) && pwdata[`CTRL_FREEZE_REQ];
  wire [`IRQ_BITS-1:0] evt_vec = {alarm_hit, chg_hit, sig_hit};
  wire addr_ok = sram_hit || (paddr <= `ADDR_IRQ_MASK && paddr[1:0] == 2'b00);

  // ==========================================
  // Power state machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      wake_pkg::st_active:
        // pattern present cancels the freeze attempt
        if (freeze_req && !wake_evt)
          state_next = wake_pkg::st_freeze;
      wake_pkg::st_freeze:
        // leave only on full match or other wake source
        if (wake_evt)
          state_next = wake_pkg::st_active;
      default:
        state_next = wake_pkg::st_active;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_reg <= wake_pkg::st_active;
    else if (ce)
      state_reg <= state_next;
  end

  // ==========================================
  // Register writes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg_reg <= '0;
      ctrl_reg <= `CTRL_RESET;
      alarm_reg <= `ALARM_RESET;
      irq_mask_reg <= '0;
    end
    else if (ce)
    begin
      if (wr_en && !in_freeze)
      begin
        case (paddr)
          `ADDR_CTRL: ctrl_reg[2:1] <= pwdata[2:1];
          `ADDR_SIG_EN: cfg_reg.sig_en <= pwdata;
          `ADDR_SIG_LVL: cfg_reg.sig_lvl <= pwdata;
          `ADDR_CHG_EN: cfg_reg.chg_en <= pwdata;
          `ADDR_ALARM: alarm_reg <= pwdata;
          `ADDR_IRQ_MASK: irq_mask_reg <= pwdata[`IRQ_BITS-1:0];
          default: ;
        endcase
      end
      if (alarm_hit)
        ctrl_reg[`CTRL_ALARM_ARM] <= 1'b0;
    end
  end

  // Counter restarts on alarm write so software sets a relative delay
  always_ff @(posedge clk)
  begin
    if (srst)
      count_reg <= '0;
    else if (ce)
    begin
      if (wr_en && !in_freeze && paddr == `ADDR_ALARM)
        count_reg <= '0;
      else if (ctrl_reg[`CTRL_ALARM_ARM])
        count_reg <= count_reg + 32'h1;
    end
  end

  // Sticky events: set wins over write-one-clear
  always_ff @(posedge clk)
  begin
    if (srst)
      irq_stat_reg <= '0;
    else if (ce)
    begin
      if (wr_en && paddr == `ADDR_IRQ_STAT)
        irq_stat_reg <= (irq_stat_reg & ~pwdata[`IRQ_BITS-1:0]) | evt_vec;
      else
        irq_stat_reg <= irq_stat_reg | evt_vec;
    end
  end

  // ==========================================
  // Fabric SRAM
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (wr_en && sram_hit && !in_freeze)
        sram[sram_idx] <= pwdata;
      // sleep mode overwrites the one addressed word with SLEEP_FILL on freeze entry
      else if (!ctrl_reg[`CTRL_RETAIN] && state_next == wake_pkg::st_freeze && !in_freeze)
        sram[sram_idx] <= `SLEEP_FILL;
    end
  end

  // ==========================================
  // Read data
  wire [31:0] status_word = {30'h0, ctrl_reg[`CTRL_RETAIN], in_freeze};
  wire [31:0] rd_mux =
    sram_hit ? sram[sram_idx] :
    (paddr == `ADDR_CTRL) ? {29'h0, ctrl_reg} :
    (paddr == `ADDR_STATUS) ? status_word :
    (paddr == `ADDR_SIG_EN) ? cfg_reg.sig_en :
    (paddr == `ADDR_SIG_LVL) ? cfg_reg.sig_lvl :
    (paddr == `ADDR_CHG_EN) ? cfg_reg.chg_en :
    (paddr == `ADDR_ALARM) ? alarm_reg :
    (paddr == `ADDR_COUNT) ? count_reg :
    (paddr == `ADDR_IRQ_STAT) ? {29'h0, irq_stat_reg} :
    (paddr == `ADDR_IRQ_MASK) ? {29'h0, irq_mask_reg} : 32'h0;

  always_ff @(posedge clk)
  begin
    if (srst)
      prdata_reg <= '0;
    else if (ce && psel && !penable && !pwrite)
      prdata_reg <= rd_mux;
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign frozen = in_freeze;
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ==========================================
  // Checks
  chk_read_ready: assert property (@(posedge clk) disable iff (srst) rd_en |-> pready)
    else $error("pready low on read");
  chk_sig_wake_exit: assert property (
    @(posedge clk) disable iff (srst) (ce && in_freeze && sig_hit) |=> !frozen)
    else $error("signature match did not wake");
  chk_pattern_blocks: assert property (
    @(posedge clk) disable iff (srst) (ce && !in_freeze && sig_hit) |=> !frozen)
    else $error("froze with pattern present");
  chk_and_combine: assert property (
    @(posedge clk) disable iff (srst) sig_hit |-> ((sync2_reg & en_n) == (lvl_n & en_n)))
    else $error("partial match woke");
  chk_chg_wake: assert property (
    @(posedge clk) disable iff (srst) (ce && in_freeze && chg_hit) |=> !frozen)
    else $error("change did not wake");
  chk_alarm_irq: assert property (
    @(posedge clk) disable iff (srst) (ce && alarm_hit) |=> irq_stat_reg[`IRQ_ALARM] && !frozen)
    else $error("alarm no irq or wake");
  chk_alarm_once: assert property (
    @(posedge clk) disable iff (srst) (ce && alarm_hit) |=> !ctrl_reg[`CTRL_ALARM_ARM])
    else $error("alarm not single shot");
  chk_cfg_static: assert property (
    @(posedge clk) disable iff (srst) in_freeze && $past(in_freeze) |-> $stable(cfg_reg))
    else $error("config changed in freeze");
  chk_pin_sync: assert property (
    @(posedge clk) disable iff (srst) ce && $past(ce) |-> sync2_reg == $past(sync1_reg))
    else $error("sync chain broken");
  chk_freeze_entry: assert property (
    @(posedge clk) disable iff (srst) (ce && freeze_req && !in_freeze && !wake_evt) |=> frozen)
    else $error("freeze not entered");
  chk_stay_frozen: assert property (
    @(posedge clk) disable iff (srst) (ce && in_freeze && !wake_evt) |=> frozen)
    else $error("left freeze without wake");
  chk_sig_sticky: assert property (
    @(posedge clk) disable iff (srst) (ce && sig_hit) |=> irq_stat_reg[`IRQ_SIG])
    else $error("signature flag not set");
  chk_chg_sticky: assert property (
    @(posedge clk) disable iff (srst) (ce && chg_hit) |=> irq_stat_reg[`IRQ_CHG])
    else $error("change flag not set");
  chk_w1c_clear: assert property (
    @(posedge clk) disable iff (srst)
    (ce && wr_en && paddr == `ADDR_IRQ_STAT && pwdata[`IRQ_CHG] && !chg_hit) |=> !irq_stat_reg[`IRQ_CHG])
    else $error("change flag not cleared");
  chk_ce_hold: assert property (
    @(posedge clk) disable iff (srst) !ce |=> $stable(state_reg) && $stable(irq_stat_reg) && $stable(cfg_reg))
    else $error("state moved with clock enable low");
  chk_count_hold: assert property (
    @(posedge clk) disable iff (srst)
    (ce && !ctrl_reg[`CTRL_ALARM_ARM] && !(wr_en && !in_freeze && paddr == `ADDR_ALARM)) |=> $stable(count_reg))
    else $error("counter ran while disarmed");
  chk_prev_follow: assert property (
    @(posedge clk) disable iff (srst) ce |=> prev_reg == $past(sync2_reg))
    else $error("edge history lost");
  chk_cfg_write: assert property (
    @(posedge clk) disable iff (srst) (ce && !in_freeze && wr_en && paddr == `ADDR_SIG_EN) |=> cfg_reg.sig_en == $past(pwdata))
    else $error("enable write lost");
  chk_retain_frozen: assert property (
    @(posedge clk) disable iff (srst) (ce && in_freeze) |=> $stable(ctrl_reg[`CTRL_RETAIN]))
    else $error("retain setting changed in freeze");
  chk_sleep_entry: assert property (
    @(posedge clk) disable iff (srst)
    (ce && freeze_req && !in_freeze && !wake_evt && !ctrl_reg[`CTRL_RETAIN]) |=> frozen)
    else $error("sleep mode freeze not entered");
  chk_irq_level: assert property (
    @(posedge clk) disable iff (srst) (|(irq_stat_reg & irq_mask_reg)) |-> irq)
    else $error("interrupt low with flag set");
  chk_unmapped_err: assert property (
    @(posedge clk) disable iff (srst) (psel && penable && !addr_ok) |-> pslverr)
    else $error("no error on unmapped access");
  chk_alarm_count: assert property (
    @(posedge clk) disable iff (srst)
    (ce && ctrl_reg[`CTRL_ALARM_ARM] && !(wr_en && !in_freeze && paddr == `ADDR_ALARM)) |=> count_reg == $past(count_reg) + 32'h1)
    else $error("armed counter stalled");
  chk_alarm_restart: assert property (
    @(posedge clk) disable iff (srst) (ce && wr_en && !in_freeze && paddr == `ADDR_ALARM) |=> count_reg == 32'h0)
    else $error("counter not restarted");
endmodule : freeze_mode_wake_matcher
`default_nettype wire

// ### freeze_mode_wake_matcher_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "wake_params.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module freeze_mode_wake_matcher_test;
  logic clk = 0, srst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, frozen, irq, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, c;
  logic [3:0] target = 0, pins;
  logic [11:0] ra[5] = '{`ADDR_SIG_EN, `ADDR_SIG_LVL, `ADDR_CHG_EN, `ADDR_IRQ_MASK, 12'h024};
  logic [31:0] rd[5] = '{32'hf, 32'h3, 32'h0, 32'h7, 32'h5};
  logic [31:0] re[5] = '{32'hf, 32'h3, 32'h0, 32'h7, 32'h0};
  int failures = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  freeze_mode_wake_matcher freeze_mode_wake_matcher_inst (.clk(clk), .srst(srst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_pins(pins), .frozen(frozen), .irq(irq));
  wake_pins_model wake_pins_model_inst (.clk(clk), .target(target), .pins(pins));
  // ==========================================
  // Bus and wait helpers
  task automatic stop_test;
    $display("failures %0d cmp_count %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n == 50)
    begin
      failures++;
      stop_test();
    end
  endtask : apb
  task automatic wait_frozen(input logic v);
    int n;
    n = 0;
    while (frozen !== v && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(frozen, v)
    if (n == 200)
      stop_test();
  endtask : wait_frozen
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 0;
    apb(0, `ADDR_CTRL, 0);
    `CHK(q, 32'h2)
    apb(0, `ADDR_ALARM, 0);
    `CHK(q, 32'hffffffff)
    `CHK({frozen, irq}, 2'b00)
    for (int i = 0; i < 5; i++)
    begin
      apb(1, ra[i], rd[i]);
      apb(0, ra[i], 0);
      `CHK({q, err}, {re[i], i == 4})
    end
    apb(1, 12'h400, 32'h12345678);
    apb(1, `ADDR_CTRL, 32'h3);
    wait_frozen(1);
    target <= 4'h1;
    repeat (8) @(posedge clk);
    `CHK(frozen, 1'b1)
    target <= 4'h3;
    wait_frozen(0);
    apb(0, `ADDR_IRQ_STAT, 0);
    `CHK({q, irq}, {32'h1, 1'b1})
    apb(1, `ADDR_CTRL, 32'h3);
    repeat (4) @(posedge clk);
    `CHK(frozen, 1'b0)
    target <= 4'h0;
    repeat (4) @(posedge clk);
    apb(1, `ADDR_IRQ_STAT, 32'h1);
    @(posedge clk);
    `CHK(irq, 1'b0)
    apb(1, `ADDR_SIG_EN, 0);
    apb(1, `ADDR_CHG_EN, 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      apb(1, `ADDR_CTRL, 32'h3);
      wait_frozen(1);
      apb(1, `ADDR_SIG_EN, 32'hf);
      target <= target ^ 4'h1;
      wait_frozen(0);
      apb(0, `ADDR_SIG_EN, 0);
      `CHK(q, 32'h0)
    end
    apb(1, `ADDR_IRQ_STAT, 32'h2);
    apb(1, `ADDR_CTRL, 32'h6);
    apb(1, `ADDR_ALARM, 32'h40);
    apb(1, `ADDR_CTRL, 32'h7);
    wait_frozen(1);
    apb(0, `ADDR_STATUS, 0);
    `CHK(q, 32'h3)
    wait_frozen(0);
    apb(0, `ADDR_IRQ_STAT, 0);
    `CHK({q, irq}, {32'h4, 1'b1})
    apb(0, `ADDR_COUNT, 0);
    c = q;
    apb(0, `ADDR_COUNT, 0);
    `CHK({q == c, c >= 32'h40}, 2'b11)
    apb(0, 12'h400, 0);
    `CHK(q, 32'h12345678)
    // Sleep mode freeze, then a clock-enable stall while frozen
    apb(1, `ADDR_CTRL, 32'h0);
    apb(1, `ADDR_CTRL, 32'h1);
    wait_frozen(1);
    apb(0, `ADDR_STATUS, 0);
    `CHK(q, 32'h1)
    ce <= 0;
    target <= target ^ 4'h1;
    repeat (8) @(posedge clk);
    `CHK(frozen, 1'b1)
    ce <= 1;
    wait_frozen(0);
    // Reset in mid-run
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    apb(0, `ADDR_SIG_EN, 0);
    `CHK({q, irq, frozen}, {32'h0, 2'b00})
    apb(0, `ADDR_CTRL, 0);
    `CHK(q, 32'h2)
    stop_test();
  end
endmodule : freeze_mode_wake_matcher_test
`default_nettype wire

// ### wake_params.svh
// How it works
// - Each pin configurable as high or low level wake
// - Participating pin matches combine by AND
// - Exit freeze when all participating pins match, or on a change or alarm wake
// - Pattern present blocks freeze entry, stays active
// - Retain mode, if set before the freeze request write, keeps SRAM contents through freeze
// - Sleep mode lets SRAM contents be lost
// - Change-mode pin wakes on any transition
// - Single-shot alarm raises interrupt and wakes
`ifndef WAKE_PARAMS_SVH
`define WAKE_PARAMS_SVH
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_SIG_EN 12'h008
`define ADDR_SIG_LVL 12'h00c
`define ADDR_CHG_EN 12'h010
`define ADDR_ALARM 12'h014
`define ADDR_COUNT 12'h018
`define ADDR_IRQ_STAT 12'h01c
`define ADDR_IRQ_MASK 12'h020
`define CTRL_FREEZE_REQ 0
`define CTRL_RETAIN 1
`define CTRL_ALARM_ARM 2
`define IRQ_SIG 0
`define IRQ_CHG 1
`define IRQ_ALARM 2
`define IRQ_BITS 3
`define ALARM_RESET 32'hffffffff
`define CTRL_RESET 3'h2
`define SRAM_BASE_ADDR 12'h400
`define SLEEP_FILL 32'hdeadbeef
`endif

// ### wake_pins_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Switch bank in front of the wake pins
module wake_pins_model #(
  parameter int NPINS = 4
) (
  input wire logic clk, // Always-on clock
  input wire logic [NPINS-1:0] target, // Wanted switch setting
  output logic [NPINS-1:0] pins // Pin levels
);
  // whole pattern set or removed at one edge
  always_ff @(posedge clk)
    pins <= target;
endmodule : wake_pins_model
`default_nettype wire

// ### wake_pkg.sv
`default_nettype none
package wake_pkg;
  typedef enum logic [1:0] {
    st_active = 2'b01,
    st_freeze = 2'b10
  } pstate_type;
  typedef struct packed {
    logic [31:0] sig_en;
    logic [31:0] sig_lvl;
    logic [31:0] chg_en;
  } wake_cfg_type;
endpackage : wake_pkg
`default_nettype wire
